/* File: src/adcc_top.sv */
/*
 * Converter control block: clock gate and reset hold, mode register,
 * conversion interrupt with priority, analog pin direction, event status.
 * Assumes a single 40 MHz sys_clk and a one-cycle strobe register port.
 */
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/10ps
module adcc_top (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Register port
    input wire logic [adcc_pkg::ADCC_ADDR_W-1:0] regAddr,
    input wire logic [adcc_pkg::ADCC_DATA_W-1:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    output logic [adcc_pkg::ADCC_DATA_W-1:0] regRdData,
    // Event link
    input wire logic hwTrigger,
    // Converter analog side
    input wire logic [adcc_pkg::ADCC_RES_W-1:0] sampleIn,
    output logic convClkEn,
    output logic convRstHold,
    output logic compEnable,
    // Conversion interrupt
    output logic convIntReq,
    output logic [1:0] convIntLevel,
    // Event interrupt
    output logic irq,
    // Analog pin
    input wire logic analogPinIn,
    output logic analogPinOut,
    output logic analogPinOeN
);
    import adcc_pkg::*;

    adcc_conv_if cv ();

    logic [7:0] pclkEn_r;
    logic [7:0] mode_r;
    logic [7:0] trig_r;
    logic [7:0] port2Dir_r;
    logic [7:0] port2Data_r;
    logic [EV_W-1:0] evStat_r;
    logic [EV_W-1:0] evStat_nxt;
    logic [EV_W-1:0] evEn_r;
    logic [7:0] rdData_r;
    logic [7:0] rdData_nxt;
    logic rstHold_r;
    logic clkOn_r;
    logic compEn_r;
    logic irq_r;
    logic pinOut_r;
    logic pinOeN_r;
    logic pinMeta_r;
    logic pinSync_r;
    logic convWrOk;
    logic intFlag;
    logic intMask;
    logic prioHi;
    logic prioLo;
    logic intReq;
    logic [1:0] intLevel;
    logic [EV_W-1:0] evSet;

    // Write strobe for one register offset
    function automatic logic wrHit(input logic [7:0] addr, input logic en, input logic [7:0] off);
        wrHit = en && (addr == off);
    endfunction : wrHit

    // Converter registers only take writes while its clock is supplied
    assign convWrOk = pclkEn_r[BIT_CLK_EN];

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pclkEn_r <= RST_PCLK_EN;
        end else if (wrHit(regAddr, regWrEn, ADDR_PCLK_EN)) begin
            pclkEn_r <= regWrData;
        end
    end

    // Mode register: run bit self-clears after a software one-shot; a write in the same cycle wins
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mode_r <= RST_MODE;
        end else if (!convWrOk) begin
            mode_r <= RST_MODE;
        end else if (wrHit(regAddr, regWrEn, ADDR_MODE)) begin
            mode_r <= regWrData;
        end else if (cv.done && !trig_r[BIT_HW_TRIG]) begin
            mode_r[BIT_CONV_OP] <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            trig_r <= RST_TRIG;
        end else if (!convWrOk) begin
            trig_r <= RST_TRIG;
        end else if (wrHit(regAddr, regWrEn, ADDR_TRIG)) begin
            trig_r <= regWrData;
        end
    end

    // Converter clock gate, reset hold and comparator enable
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            clkOn_r <= 1'b0;
            rstHold_r <= 1'b1;
            compEn_r <= 1'b0;
        end else begin
            clkOn_r <= pclkEn_r[BIT_CLK_EN];
            rstHold_r <= ~pclkEn_r[BIT_CLK_EN];
            compEn_r <= pclkEn_r[BIT_CLK_EN] & mode_r[BIT_COMP_EN];
        end
    end

    assign cv.rstHold = rstHold_r;
    assign cv.hwMode = trig_r[BIT_HW_TRIG];
    assign cv.runEn = mode_r[BIT_CONV_OP];

    adcc_conv u_conv (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .cv (cv.core),
        .hwTrigger (hwTrigger),
        .sampleIn (sampleIn)
    );

    adcc_irq u_irq (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .doneEvt (cv.done),
        .flagWr (wrHit(regAddr, regWrEn, ADDR_INT_REQ)),
        .maskWr (wrHit(regAddr, regWrEn, ADDR_INT_MASK)),
        .prioHiWr (wrHit(regAddr, regWrEn, ADDR_PRIO_HI)),
        .prioLoWr (wrHit(regAddr, regWrEn, ADDR_PRIO_LO)),
        .wrBit (regWrData[BIT_INT]),
        .flag (intFlag),
        .mask (intMask),
        .prioHi (prioHi),
        .prioLo (prioLo),
        .intReq (intReq),
        .intLevel (intLevel)
    );

    // Analog pin: direction and output latch, input sampled through two flops
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            port2Dir_r <= RST_PORT2_DIR;
            port2Data_r <= RST_PORT2_DATA;
        end else begin
            if (wrHit(regAddr, regWrEn, ADDR_PORT2_DIR)) begin
                port2Dir_r <= regWrData;
            end
            if (wrHit(regAddr, regWrEn, ADDR_PORT2_DATA)) begin
                port2Data_r <= regWrData;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pinMeta_r <= 1'b0;
            pinSync_r <= 1'b0;
            pinOut_r <= 1'b0;
            pinOeN_r <= 1'b1;
        end else begin
            pinMeta_r <= analogPinIn;
            pinSync_r <= pinMeta_r;
            pinOut_r <= port2Data_r[BIT_ANALOG_DIR];
            pinOeN_r <= port2Dir_r[BIT_ANALOG_DIR];
        end
    end

    // Event status: sticky, write one to clear, a new event wins over the clear
    always_comb begin
        evSet = '0;
        evSet[BIT_EV_DONE] = cv.done;
        evSet[BIT_EV_OVR] = cv.overrun;
        evStat_nxt = evStat_r;
        if (wrHit(regAddr, regWrEn, ADDR_EV_STAT)) begin
            evStat_nxt = evStat_nxt & ~regWrData[EV_W-1:0];
        end
        evStat_nxt = evStat_nxt | evSet;
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            evStat_r <= RST_EV;
            evEn_r <= RST_EV;
            irq_r <= 1'b0;
        end else begin
            evStat_r <= evStat_nxt;
            if (wrHit(regAddr, regWrEn, ADDR_EV_EN)) begin
                evEn_r <= regWrData[EV_W-1:0];
            end
            irq_r <= |(evStat_r & evEn_r);
        end
    end

    // Read path; converter registers read as zero while held in reset
    always_comb begin
        rdData_nxt = 8'h00;
        case (regAddr)
            ADDR_PCLK_EN: rdData_nxt = pclkEn_r;
            ADDR_MODE: rdData_nxt = mode_r;
            ADDR_TRIG: rdData_nxt = trig_r;
            ADDR_RES_LO: rdData_nxt = cv.result[7:0];
            ADDR_RES_HI: rdData_nxt = {6'h00, cv.result[ADCC_RES_W-1:8]};
            ADDR_INT_MASK: rdData_nxt[BIT_INT] = intMask;
            ADDR_INT_REQ: rdData_nxt[BIT_INT] = intFlag;
            ADDR_PRIO_HI: rdData_nxt[BIT_INT] = prioHi;
            ADDR_PRIO_LO: rdData_nxt[BIT_INT] = prioLo;
            ADDR_PORT2_DIR: rdData_nxt = port2Dir_r;
            ADDR_PORT2_DATA: begin
                rdData_nxt = port2Data_r;
                if (port2Dir_r[BIT_ANALOG_DIR]) begin
                    rdData_nxt[BIT_ANALOG_DIR] = pinSync_r;
                end
            end
            ADDR_EV_STAT: rdData_nxt[EV_W-1:0] = evStat_r;
            ADDR_EV_EN: rdData_nxt[EV_W-1:0] = evEn_r;
            default: rdData_nxt = 8'h00;
        endcase
    end

    // Read data stand for exactly the cycle after the strobe
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdData_r <= 8'h00;
        end else if (regRdEn) begin
            rdData_r <= rdData_nxt;
        end else begin
            rdData_r <= 8'h00;
        end
    end

    assign regRdData = rdData_r;
    assign convClkEn = clkOn_r;
    assign convRstHold = rstHold_r;
    assign compEnable = compEn_r;
    assign convIntReq = intReq;
    assign convIntLevel = intLevel;
    assign irq = irq_r;
    assign analogPinOut = pinOut_r;
    assign analogPinOeN = pinOeN_r;
endmodule : adcc_top

/* File: src/adcc_pkg.sv */
/*
 * Shared constants for the converter control block: register offsets,
 * bit positions, reset values, conversion timing and the sequencer states.
 * Assumes a 40 MHz sys_clk and an 8-bit register port.
 */
package adcc_pkg;
    localparam int ADCC_ADDR_W = 8;
    localparam int ADCC_DATA_W = 8;
    localparam int ADCC_RES_W = 10;
    localparam int ADCC_CNT_W = 8;

    // Register offsets
    localparam logic [7:0] ADDR_PCLK_EN = 8'h00;
    localparam logic [7:0] ADDR_MODE = 8'h01;
    localparam logic [7:0] ADDR_TRIG = 8'h02;
    localparam logic [7:0] ADDR_RES_LO = 8'h03;
    localparam logic [7:0] ADDR_RES_HI = 8'h04;
    localparam logic [7:0] ADDR_INT_MASK = 8'h05;
    localparam logic [7:0] ADDR_INT_REQ = 8'h06;
    localparam logic [7:0] ADDR_PRIO_HI = 8'h07;
    localparam logic [7:0] ADDR_PRIO_LO = 8'h08;
    localparam logic [7:0] ADDR_PORT2_DIR = 8'h09;
    localparam logic [7:0] ADDR_PORT2_DATA = 8'h0A;
    localparam logic [7:0] ADDR_EV_STAT = 8'h0B;
    localparam logic [7:0] ADDR_EV_EN = 8'h0C;

    // Bit positions
    localparam int BIT_CLK_EN = 5;
    localparam int BIT_CONV_OP = 7;
    localparam int BIT_CHAN_MODE = 6;
    localparam int BIT_COMP_EN = 0;
    localparam int BIT_INT = 0;
    localparam int BIT_ANALOG_DIR = 0;
    localparam int BIT_HW_TRIG = 0;
    localparam int BIT_EV_DONE = 0;
    localparam int BIT_EV_OVR = 1;
    localparam int EV_W = 2;

    // Reset values
    localparam logic [7:0] RST_PCLK_EN = 8'h00;
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [7:0] RST_TRIG = 8'h00;
    localparam logic [7:0] RST_PORT2_DIR = 8'hFF;
    localparam logic [7:0] RST_PORT2_DATA = 8'h00;
    localparam logic RST_INT_MASK = 1'b1;
    localparam logic RST_PRIO = 1'b1;
    localparam logic [1:0] RST_EV = 2'h0;

    // Timing
    localparam int CLK_PERIOD_PS = 25000;
    localparam int CONV_TIME_NS = 2375;
    localparam int STAB_TIME_NS = 1000;
    localparam logic [7:0] CONV_CYCLES = 8'((CONV_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [7:0] STAB_CYCLES = 8'((STAB_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ARMED = 2'b01,
        ST_STAB = 2'b10,
        ST_CONV = 2'b11
    } adcc_state_t;
endpackage : adcc_pkg

/* File: src/adcc_conv_if.sv */
/*
 * Link between the register side and the conversion sequencer.
 * Both ends run on sys_clk.
 */
`timescale 1ns/10ps
interface adcc_conv_if;
    import adcc_pkg::*;
    logic rstHold;
    logic hwMode;
    logic runEn;
    logic busy;
    logic done;
    logic overrun;
    logic [ADCC_RES_W-1:0] result;
    modport ctrl (output rstHold, output hwMode, output runEn, input busy, input done, input overrun,
        input result);
    modport core (input rstHold, input hwMode, input runEn, output busy, output done, output overrun,
        output result);
endinterface : adcc_conv_if

/* File: src/adcc_conv.sv */
/*
 * Conversion sequencer: software-started or event-started conversions,
 * with a stabilisation wait before each event-started one.
 * Assumes trigger and sample inputs are asynchronous to sys_clk.
 */
`timescale 1ns/10ps
module adcc_conv (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Control link
    adcc_conv_if.core cv,
    // Outside world
    input wire logic hwTrigger,
    input wire logic [adcc_pkg::ADCC_RES_W-1:0] sampleIn
);
    import adcc_pkg::*;

    logic [2:0] trigSync_r;
    logic [ADCC_RES_W-1:0] sampleMeta_r;
    logic [ADCC_RES_W-1:0] sampleSync_r;
    logic [ADCC_CNT_W-1:0] cnt_r;
    logic [ADCC_RES_W-1:0] result_r;
    logic done_r;
    logic overrun_r;
    logic trigRise;
    adcc_state_t state_r;

    // Stage two and its delayed copy feed the edge detector, never stage one
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            trigSync_r <= 3'h0;
            sampleMeta_r <= '0;
            sampleSync_r <= '0;
        end else begin
            trigSync_r <= {trigSync_r[1:0], hwTrigger};
            sampleMeta_r <= sampleIn;
            sampleSync_r <= sampleMeta_r;
        end
    end

    assign trigRise = trigSync_r[1] & ~trigSync_r[2];

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= ST_IDLE;
            cnt_r <= '0;
            done_r <= 1'b0;
            overrun_r <= 1'b0;
            result_r <= '0;
        end else if (cv.rstHold || !cv.runEn) begin
            state_r <= ST_IDLE;
            cnt_r <= '0;
            done_r <= 1'b0;
            overrun_r <= 1'b0;
            if (cv.rstHold) begin
                result_r <= '0;
            end
        end else begin
            done_r <= 1'b0;
            overrun_r <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    if (cv.hwMode) begin
                        state_r <= ST_ARMED;
                    end else begin
                        state_r <= ST_CONV;
                        cnt_r <= CONV_CYCLES - 8'h01;
                    end
                end
                ST_ARMED: begin
                    // In software mode this state only waits for the run bit to drop
                    if (cv.hwMode && trigRise) begin
                        state_r <= ST_STAB;
                        cnt_r <= STAB_CYCLES - 8'h01;
                    end
                end
                ST_STAB: begin
                    overrun_r <= trigRise;
                    if (cnt_r == '0) begin
                        state_r <= ST_CONV;
                        cnt_r <= CONV_CYCLES - 8'h01;
                    end else begin
                        cnt_r <= cnt_r - 8'h01;
                    end
                end
                ST_CONV: begin
                    overrun_r <= trigRise & cv.hwMode;
                    if (cnt_r == '0) begin
                        state_r <= ST_ARMED;
                        done_r <= 1'b1;
                        result_r <= sampleSync_r;
                    end else begin
                        cnt_r <= cnt_r - 8'h01;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    assign cv.busy = (state_r == ST_STAB) || (state_r == ST_CONV);
    assign cv.done = done_r;
    assign cv.overrun = overrun_r;
    assign cv.result = result_r;
endmodule : adcc_conv

/* File: src/adcc_irq.sv */
/*
 * Conversion-complete interrupt: request flag, mask and two-bit priority.
 * Assumes write strobes come from the register decoder on sys_clk.
 */
`timescale 1ns/10ps
module adcc_irq (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Event and register writes
    input wire logic doneEvt,
    input wire logic flagWr,
    input wire logic maskWr,
    input wire logic prioHiWr,
    input wire logic prioLoWr,
    input wire logic wrBit,
    // State
    output logic flag,
    output logic mask,
    output logic prioHi,
    output logic prioLo,
    output logic intReq,
    output logic [1:0] intLevel
);
    import adcc_pkg::*;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            flag <= 1'b0;
        end else if (doneEvt) begin
            flag <= 1'b1;
        end else if (flagWr) begin
            flag <= wrBit;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mask <= RST_INT_MASK;
            prioHi <= RST_PRIO;
            prioLo <= RST_PRIO;
        end else begin
            if (maskWr) begin
                mask <= wrBit;
            end
            if (prioHiWr) begin
                prioHi <= wrBit;
            end
            if (prioLoWr) begin
                prioLo <= wrBit;
            end
        end
    end

    // Request is held while the flag is pending and servicing is allowed
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            intReq <= 1'b0;
            intLevel <= {RST_PRIO, RST_PRIO};
        end else begin
            intReq <= flag & ~mask;
            intLevel <= {prioHi, prioLo};
        end
    end
endmodule : adcc_irq

/* File: tb/adcc_top_asserts.sv */
/*
 * Port-level checks for the converter control block.
 * Assumes one sys_clk domain and the one-cycle strobe register port.
 */
`timescale 1ns/10ps
module adcc_top_asserts (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Register port
    input wire logic [adcc_pkg::ADCC_ADDR_W-1:0] regAddr,
    input wire logic [adcc_pkg::ADCC_DATA_W-1:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [adcc_pkg::ADCC_DATA_W-1:0] regRdData,
    // Converter, interrupt and analog pin outputs
    input wire logic convClkEn,
    input wire logic convRstHold,
    input wire logic compEnable,
    input wire logic convIntReq,
    input wire logic [1:0] convIntLevel,
    input wire logic analogPinOeN
);
    import adcc_pkg::*;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_wr(logic [7:0] a);
        regWrEn && regAddr == a;
    endsequence

    // Register write lands on the edge, the registered output one edge later
    sequence s_settle;
        ##2 1'b1;
    endsequence

    AST_CLK_FOLLOW: assert property (s_wr(ADDR_PCLK_EN) |-> s_settle ##0 convClkEn == $past(regWrData[5], 2))
        else $error("converter clock does not follow the enable bit");
    AST_RST_HOLD: assert property (convRstHold != convClkEn)
        else $error("converter reset hold disagrees with its clock");
    AST_COMP_GATE: assert property (compEnable |-> convClkEn)
        else $error("comparator enabled while converter clock is off");
    AST_MODE_LOCK: assert property (s_wr(ADDR_MODE) ##0 (!convClkEn && !$past(regWrEn)) |-> ##2 !compEnable)
        else $error("mode write took effect while clock gated");
    AST_COMP_SET: assert property (s_wr(ADDR_MODE) ##0 (convClkEn && !$past(regWrEn))
        |-> ##2 compEnable == $past(regWrData[0], 2))
        else $error("comparator does not follow mode bit 0");
    AST_MASK_BLOCK: assert property (s_wr(ADDR_INT_MASK) ##0 regWrData[0] |-> ##2 !convIntReq)
        else $error("interrupt request seen while masked");
    AST_PRIO_HI: assert property (s_wr(ADDR_PRIO_HI) |-> ##2 convIntLevel[1] == $past(regWrData[0], 2))
        else $error("priority upper bit wrong");
    AST_PRIO_LO: assert property (s_wr(ADDR_PRIO_LO) |-> ##2 convIntLevel[0] == $past(regWrData[0], 2))
        else $error("priority lower bit wrong");
    AST_PIN_DIR: assert property (s_wr(ADDR_PORT2_DIR) |-> ##2 analogPinOeN == $past(regWrData[0], 2))
        else $error("pin output enable does not follow direction bit");
    AST_FLAG_READ: assert property (regRdEn && regAddr == ADDR_INT_REQ && convIntReq && !$past(regWrEn)
        |=> regRdData[0])
        else $error("pending request reads as clear");
    AST_RD_IDLE: assert property (!regRdEn |=> regRdData == 8'h00)
        else $error("read data present without a read");
endmodule : adcc_top_asserts

/* File: tb/adcc_top_tb.sv */
/*
 * Self-checking bench for the converter control block: register port,
 * clock gate, interrupt flag, mask, priority, pin direction and triggers.
 * Assumes the design package and a 40 MHz sys_clk.
 */
`timescale 1ns/10ps
module adcc_top_tb;
    import adcc_pkg::*;
    logic sys_clk, sys_rst, regWrEn, regRdEn, hwTrigger, analogPinIn;
    logic [7:0] regAddr, regWrData, regRdData, dirVal;
    logic [9:0] sampleIn, smp;
    logic convClkEn, convRstHold, compEnable, convIntReq, irq, analogPinOut, analogPinOeN, pinVal;
    logic [1:0] convIntLevel, lvl;
    int fails, checks_done, cnt, n;
    logic [7:0] rstAddr [11] = '{ADDR_PCLK_EN, ADDR_MODE, ADDR_TRIG, ADDR_INT_MASK, ADDR_INT_REQ,
        ADDR_PRIO_HI, ADDR_PRIO_LO, ADDR_PORT2_DIR, ADDR_EV_STAT, ADDR_EV_EN, 8'h3C};
    logic [7:0] rstVal [11] = '{RST_PCLK_EN, RST_MODE, RST_TRIG, 8'h01, 8'h00, 8'h01, 8'h01,
        RST_PORT2_DIR, 8'h00, 8'h00, 8'h00};

    adcc_top i_adcc_top (.sys_clk(sys_clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
        .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .hwTrigger(hwTrigger),
        .sampleIn(sampleIn), .convClkEn(convClkEn), .convRstHold(convRstHold), .compEnable(compEnable),
        .convIntReq(convIntReq), .convIntLevel(convIntLevel), .irq(irq), .analogPinIn(analogPinIn),
        .analogPinOut(analogPinOut), .analogPinOeN(analogPinOeN));

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regWrEn <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge sys_clk);
        regWrEn <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rdChk(input string what, input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        regRdEn <= 1'b1;
        regAddr <= a;
        @(posedge sys_clk);
        regRdEn <= 1'b0;
        #1;
        check(what, regRdData, exp);
    endtask : rdChk

    task automatic waitEv(input int maxc);
        cnt = 0;
        while (irq !== 1'b1) begin
            @(posedge sys_clk);
            #1;
            cnt++;
            if (cnt > maxc) begin
                fails++;
                $display("ERROR event interrupt expected 1 seen %b", irq);
                conclude();
            end
        end
    endtask : waitEv

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    initial begin
        sys_rst = 1'b1;
        regAddr = 8'h00;
        regWrData = 8'h00;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        hwTrigger = 1'b0;
        sampleIn = 10'h000;
        analogPinIn = 1'b0;
        fails = 0;
        checks_done = 0;
        n = $urandom(32'hA534A045);
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        #1;
        check("reset pins", {convClkEn, convRstHold, compEnable, convIntReq, convIntLevel, irq, analogPinOeN},
            8'b0100_1101);
        for (int i = 0; i < 11; i++) rdChk("reset value", rstAddr[i], rstVal[i]);
        $display("test reset done");

        wr(ADDR_MODE, 8'h41);
        rdChk("mode while gated", ADDR_MODE, 8'h00);
        wr(ADDR_PCLK_EN, 8'h20);
        wr(ADDR_MODE, 8'h41);
        rdChk("mode write", ADDR_MODE, 8'h41);
        check("clock and comparator", {convClkEn, convRstHold, compEnable}, 3'b101);
        wr(ADDR_MODE, 8'h40);
        rdChk("comparator stop", ADDR_MODE, 8'h40);
        check("comparator off", compEnable, 1'b0);
        wr(ADDR_PCLK_EN, 8'h00);
        rdChk("mode held in reset", ADDR_MODE, 8'h00);
        check("reset hold", {convClkEn, convRstHold}, 2'b01);
        $display("test clock gate done");

        for (int i = 0; i < 8; i++) begin
            lvl = (i < 4) ? i[1:0] : 2'($urandom);
            wr(ADDR_PRIO_HI, {7'($urandom), lvl[1]});
            wr(ADDR_PRIO_LO, {7'($urandom), lvl[0]});
            rdChk("priority upper", ADDR_PRIO_HI, {7'h00, lvl[1]});
            check("priority level", convIntLevel, lvl);
        end
        $display("test priority done");

        for (int i = 0; i < 4; i++) begin
            pinVal = 1'($urandom);
            analogPinIn <= pinVal;
            dirVal = {7'($urandom), i[0]};
            wr(ADDR_PORT2_DIR, dirVal);
            wr(ADDR_PORT2_DATA, {7'h00, ~pinVal});
            rdChk("direction", ADDR_PORT2_DIR, dirVal);
            check("pin enable", analogPinOeN, i[0]);
            if (i[0]) rdChk("pin input", ADDR_PORT2_DATA, {7'h00, pinVal});
            else check("pin drive", analogPinOut, !pinVal);
        end
        $display("test pin done");

        // Setup in the documented order before any conversion
        wr(ADDR_PCLK_EN, 8'h20);
        wr(ADDR_MODE, 8'h00);
        wr(ADDR_INT_MASK, 8'h01);
        wr(ADDR_INT_REQ, 8'h00);
        wr(ADDR_PRIO_HI, 8'h00);
        wr(ADDR_PRIO_LO, 8'h00);
        wr(ADDR_PORT2_DIR, 8'hFF);
        wr(ADDR_EV_EN, 8'h01);
        for (int k = 0; k < 2; k++) begin
            smp = k[0] ? 10'h3FF : 10'($urandom);
            sampleIn <= smp;
            wr(ADDR_INT_MASK, {7'h00, k[0]});
            wr(ADDR_MODE, 8'h81);
            rdChk("run bit", ADDR_MODE, 8'h81);
            waitEv(300);
            check("conversion time", cnt + 2 >= CONV_CYCLES, 1'b1);
            rdChk("flag set", ADDR_INT_REQ, 8'h01);
            rdChk("run cleared", ADDR_MODE, 8'h01);
            rdChk("result low", ADDR_RES_LO, smp[7:0]);
            rdChk("result high", ADDR_RES_HI, {6'h00, smp[9:8]});
            check("conversion interrupt", convIntReq, !k[0]);
            if (k[0]) begin
                wr(ADDR_INT_MASK, 8'h00);
                @(posedge sys_clk);
                #1;
                check("unmasked", convIntReq, 1'b1);
            end
            wr(ADDR_INT_REQ, 8'h00);
            wr(ADDR_EV_STAT, 8'h01);
            @(posedge sys_clk);
            #1;
            check("cleared", {convIntReq, irq}, 2'b00);
        end
        $display("test software conversion done");

        wr(ADDR_TRIG, 8'h01);
        wr(ADDR_MODE, 8'h80);
        hwTrigger <= 1'b1;
        repeat (4) @(posedge sys_clk);
        hwTrigger <= 1'b0;
        // Second trigger lands inside the stabilisation wait and must be refused
        repeat (20) @(posedge sys_clk);
        hwTrigger <= 1'b1;
        waitEv(400);
        check("event conversion time", cnt + 24 >= STAB_CYCLES + CONV_CYCLES, 1'b1);
        rdChk("overrun status", ADDR_EV_STAT, 8'h03);
        rdChk("hardware run stays", ADDR_MODE, 8'h80);
        rdChk("flag from event", ADDR_INT_REQ, 8'h01);
        hwTrigger <= 1'b0;
        wr(ADDR_MODE, 8'h00);
        rdChk("stopped", ADDR_MODE, 8'h00);
        $display("test hardware trigger done");
        conclude();
    end
endmodule : adcc_top_tb

bind adcc_top adcc_top_asserts i_adcc_top_asserts (.sys_clk(sys_clk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .convClkEn(convClkEn), .convRstHold(convRstHold), .compEnable(compEnable), .convIntReq(convIntReq),
    .convIntLevel(convIntLevel), .analogPinOeN(analogPinOeN));
